// ---- inc/emb_defines.vh ----
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH

// ----------------------------------------
// operand and product geometry
// ----------------------------------------
`define EMB_WIDE_W        18
`define EMB_NARROW_W      9
`define EMB_PROD_W        36
`define EMB_LANES         2

// ----------------------------------------
// register bus geometry
// ----------------------------------------
`define EMB_ADDR_W        8
`define EMB_DATA_W        32

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define EMB_REG_CTRL      8'h00
`define EMB_REG_STATUS    8'h04
`define EMB_REG_PROD_LO   8'h08
`define EMB_REG_PROD_HI   8'h0C

// ----------------------------------------
// register select codes
// ----------------------------------------
`define EMB_SEL_NONE      3'h0
`define EMB_SEL_CTRL      3'h1
`define EMB_SEL_STATUS    3'h2
`define EMB_SEL_PROD_LO   3'h3
`define EMB_SEL_PROD_HI   3'h4

// ----------------------------------------
// control register fields
// ----------------------------------------
`define EMB_CTRL_DUAL     0
`define EMB_CTRL_REG_A    1
`define EMB_CTRL_REG_B    2
`define EMB_CTRL_REG_SA   3
`define EMB_CTRL_REG_SB   4
`define EMB_CTRL_REG_OUT  5
`define EMB_CTRL_SIGN_USE 6
`define EMB_CTRL_W        7
`define EMB_CTRL_RESET    7'h00

// ----------------------------------------
// status register fields
// ----------------------------------------
`define EMB_STAT_SIGNED   0
`define EMB_STAT_SIGN_A   1
`define EMB_STAT_SIGN_B   2
`define EMB_STAT_DUAL     3

`endif

// ---- design/emb_mult_core.v ----
`timescale 1ns/1ns
`include "emb_defines.vh"

module emb_mult_core #(
	parameter W = `EMB_NARROW_W
) (
	// operands
	input  wire [W-1:0]   opA,
	input  wire [W-1:0]   opB,
	// sign interpretation
	input  wire           isSignedA,
	input  wire           isSignedB,
	// full precision result
	output wire [2*W-1:0] product
);

	// ----------------------------------------
	// sign extended multiply
	// ----------------------------------------
	wire signed [W:0]     extA;
	wire signed [W:0]     extB;
	wire signed [2*W+1:0] fullProd;

	// one extra bit lets signed and unsigned share one signed multiplier
	assign extA     = {isSignedA & opA[W-1], opA};
	assign extB     = {isSignedB & opB[W-1], opB};
	assign fullProd = extA * extB;
	// 2W bits always hold the exact result, the top two are copies
	assign product  = fullProd[2*W-1:0];

endmodule // emb_mult_core

// ---- design/emb_mult_block.v ----
// Behaviour
// - block runs as one 18x18 multiplier or two parallel 9x9 multipliers.
// - single mode serves operand widths from 10 to 18 bits.
// - dual mode gives two independent multipliers of at most 9 bits.
// - operands go in 9 or 18 bit sections, registered or bypassed.
// - register or bypass chosen separately for each input signal.
// - all datapath registers share one clock, one clock enable, one asynchronous clear.
// - a high sign control makes its operand signed, low makes it unsigned.
// - product is signed when either operand is signed, else unsigned.
// - one sign control per operand, shared by both dual mode multipliers.
// - sign controls may change every cycle and have optional own registers.
// - product keeps full precision with no truncation or rounding.
// - product optionally registered as two 18 bit or one 36 bit section.
// - with sign controls unused the block multiplies unsigned.
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`include "emb_defines.vh"

module emb_mult_block (
	// clock and reset
	input  wire                     clk_sys,
	input  wire                     rst_n,
	// avalon-mm slave
	input  wire [`EMB_ADDR_W-1:0]   avsAddress,
	input  wire                     avsRead,
	input  wire                     avsWrite,
	input  wire [`EMB_DATA_W-1:0]   avsWriteData,
	input  wire [3:0]               avsByteEnable,
	output reg  [`EMB_DATA_W-1:0]   avsReadData,
	output reg                      avsWaitRequest,
	// shared datapath controls
	input  wire                     mulClkEn,
	input  wire                     mulClr,
	// operands and sign controls
	input  wire [`EMB_WIDE_W-1:0]   dataA,
	input  wire [`EMB_WIDE_W-1:0]   dataB,
	input  wire                     signA,
	input  wire                     signB,
	// result
	output reg  [`EMB_PROD_W-1:0]   product,
	output reg                      productSigned
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function [2:0] regSelect;
		input [`EMB_ADDR_W-1:0] addr;
		begin
			case (addr)
				`EMB_REG_CTRL:    regSelect = `EMB_SEL_CTRL;
				`EMB_REG_STATUS:  regSelect = `EMB_SEL_STATUS;
				`EMB_REG_PROD_LO: regSelect = `EMB_SEL_PROD_LO;
				`EMB_REG_PROD_HI: regSelect = `EMB_SEL_PROD_HI;
				default:          regSelect = `EMB_SEL_NONE;
			endcase
		end
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg  [`EMB_CTRL_W-1:0]   ctrl;
	wire                     modeDual;
	wire                     useRegA;
	wire                     useRegB;
	wire                     useRegSignA;
	wire                     useRegSignB;
	wire                     useRegOut;
	wire                     signUse;
	wire                     clrAll_n;
	wire [2:0]               wrSel;
	wire [2:0]               rdSel;
	wire                     busReq;

	reg  [`EMB_WIDE_W-1:0]   dataAReg;
	reg  [`EMB_WIDE_W-1:0]   dataBReg;
	reg                      signAReg;
	reg                      signBReg;
	reg  [`EMB_PROD_W-1:0]   prodReg;
	reg                      prodSignedReg;

	wire [`EMB_WIDE_W-1:0]   opA;
	wire [`EMB_WIDE_W-1:0]   opB;
	wire                     effSignA;
	wire                     effSignB;
	wire [`EMB_PROD_W-1:0]   wideProd;
	wire [`EMB_PROD_W-1:0]   dualProd;
	wire [`EMB_PROD_W-1:0]   prodComb;
	wire                     prodSignedComb;

	reg  [`EMB_DATA_W-1:0]   next_readData;

	// ----------------------------------------
	// control field taps
	// ----------------------------------------
	assign modeDual    = ctrl[`EMB_CTRL_DUAL];
	assign useRegA     = ctrl[`EMB_CTRL_REG_A];
	assign useRegB     = ctrl[`EMB_CTRL_REG_B];
	assign useRegSignA = ctrl[`EMB_CTRL_REG_SA];
	assign useRegSignB = ctrl[`EMB_CTRL_REG_SB];
	assign useRegOut   = ctrl[`EMB_CTRL_REG_OUT];
	assign signUse     = ctrl[`EMB_CTRL_SIGN_USE];

	// ----------------------------------------
	// register bus slave
	// ----------------------------------------
	assign busReq = avsRead | avsWrite;
	assign wrSel  = regSelect(avsAddress);
	assign rdSel  = regSelect(avsAddress);

	// read data mux, unmapped offsets read as zero
	always @* begin
		next_readData = 32'h0000_0000;
		case (rdSel)
			`EMB_SEL_CTRL: begin
				next_readData[`EMB_CTRL_W-1:0] = ctrl;
			end
			`EMB_SEL_STATUS: begin
				next_readData[`EMB_STAT_SIGNED] = prodSignedComb;
				next_readData[`EMB_STAT_SIGN_A] = effSignA;
				next_readData[`EMB_STAT_SIGN_B] = effSignB;
				next_readData[`EMB_STAT_DUAL]   = modeDual;
			end
			`EMB_SEL_PROD_LO: begin
				next_readData = product[31:0];
			end
			`EMB_SEL_PROD_HI: begin
				next_readData[`EMB_PROD_W-33:0] = product[`EMB_PROD_W-1:32];
			end
			default: begin
				next_readData = 32'h0000_0000;
			end
		endcase
	end

	// one wait cycle per access: request seen, then answered with waitrequest low
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avsWaitRequest <= 1'b1;
			avsReadData    <= 32'h0000_0000;
		end else if (busReq && avsWaitRequest) begin
			avsWaitRequest <= 1'b0;
			if (avsRead) begin
				avsReadData <= next_readData;
			end
		end else begin
			// back to stalling so a held request is not answered twice
			avsWaitRequest <= 1'b1;
		end
	end

	// writes land on the edge where the master sees waitrequest low
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `EMB_CTRL_RESET;
		end else if (avsWrite && !avsWaitRequest && avsByteEnable[0]) begin
			if (wrSel == `EMB_SEL_CTRL) begin
				ctrl <= avsWriteData[`EMB_CTRL_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// shared clear
	// ----------------------------------------
	// the clear from the fabric acts like reset on the datapath only;
	// it must be glitch free since it reaches flop clear pins directly
	assign clrAll_n = rst_n & ~mulClr;

	// ----------------------------------------
	// input registers
	// ----------------------------------------
	// operand registers, loaded only under the shared clock enable
	always @(posedge clk_sys or negedge clrAll_n) begin
		if (!clrAll_n) begin
			dataAReg <= 18'h0_0000;
			dataBReg <= 18'h0_0000;
		end else if (mulClkEn) begin
			dataAReg <= dataA;
			dataBReg <= dataB;
		end
	end

	// dedicated sign registers, so signs track their registered operands
	always @(posedge clk_sys or negedge clrAll_n) begin
		if (!clrAll_n) begin
			signAReg <= 1'b0;
			signBReg <= 1'b0;
		end else if (mulClkEn) begin
			signAReg <= signA;
			signBReg <= signB;
		end
	end

	// ----------------------------------------
	// per-signal bypass selection
	// ----------------------------------------
	assign opA = useRegA ? dataAReg : dataA;
	assign opB = useRegB ? dataBReg : dataB;

	// sign controls unused means both operands unsigned
	assign effSignA = signUse & (useRegSignA ? signAReg : signA);
	assign effSignB = signUse & (useRegSignB ? signBReg : signB);

	// ----------------------------------------
	// multiplier stage
	// ----------------------------------------
	// single mode: whole 18 bit operands, narrower ones sit in the low bits
	emb_mult_core #(
		.W (`EMB_WIDE_W)
	) uWide (
		.opA       (opA),
		.opB       (opB),
		.isSignedA (effSignA),
		.isSignedB (effSignB),
		.product   (wideProd)
	);

	// dual mode: two 9x9 lanes, both steered by the same two sign controls
	genvar lane;
	generate
		for (lane = 0; lane < `EMB_LANES; lane = lane + 1) begin : gLane
			emb_mult_core #(
				.W (`EMB_NARROW_W)
			) uNarrow (
				.opA       (opA[lane*`EMB_NARROW_W +: `EMB_NARROW_W]),
				.opB       (opB[lane*`EMB_NARROW_W +: `EMB_NARROW_W]),
				.isSignedA (effSignA),
				.isSignedB (effSignB),
				.product   (dualProd[lane*2*`EMB_NARROW_W +: 2*`EMB_NARROW_W])
			);
		end
	endgenerate

	// mode select; the wide core is idle logic in dual mode, a cost for simplicity
	assign prodComb       = modeDual ? dualProd : wideProd;
	assign prodSignedComb = effSignA | effSignB;

	// ----------------------------------------
	// output register
	// ----------------------------------------
	// one 36 bit register serves as two 18 bit sections in dual mode
	always @(posedge clk_sys or negedge clrAll_n) begin
		if (!clrAll_n) begin
			prodReg       <= 36'h0_0000_0000;
			prodSignedReg <= 1'b0;
		end else if (mulClkEn) begin
			prodReg       <= prodComb;
			prodSignedReg <= prodSignedComb;
		end
	end

	// ----------------------------------------
	// result outputs
	// ----------------------------------------
	// bypassed output must stay combinational, else bypass would add latency
	always @* begin
		if (useRegOut) begin
			product       = prodReg;
			productSigned = prodSignedReg;
		end else begin
			product       = prodComb;
			productSigned = prodSignedComb;
		end
	end

endmodule // emb_mult_block

// ---- verif/emb_feeder.sv ----
`timescale 1ns/1ns
module emb_feeder (
	// clock and reset
	input  logic        clk_sys,
	input  logic        rst_n,
	// values wanted by the bench
	input  logic [17:0] wantA,
	input  logic [17:0] wantB,
	input  logic        wantSa,
	input  logic        wantSb,
	// operands toward the block
	output logic [17:0] dataA,
	output logic [17:0] dataB,
	output logic        signA,
	output logic        signB
);
	// fabric flops launch after the edge; one sign per operand feeds both lanes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{dataA, dataB, signA, signB} <= '0;
		end else begin
			{dataA, dataB, signA, signB} <= {wantA, wantB, wantSa, wantSb};
		end
	end
endmodule // emb_feeder

// ---- verif/emb_mult_asserts.sv ----
`timescale 1ns/1ns
`include "emb_defines.vh"
module emb_mult_asserts (
	// clock and reset
	input logic        clk_sys,
	input logic        rst_n,
	// register bus
	input logic [7:0]  avsAddress,
	input logic        avsWrite,
	input logic [31:0] avsWriteData,
	input logic [3:0]  avsByteEnable,
	input logic        avsWaitRequest,
	// datapath
	input logic        mulClkEn,
	input logic        mulClr,
	input logic [17:0] dataA,
	input logic [17:0] dataB,
	input logic        signA,
	input logic        signB,
	input logic [35:0] product,
	input logic        productSigned
);
	logic [6:0]  shCtrl;
	logic        effA;
	logic        effB;
	// shadow of the control register, followed from accepted writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			shCtrl <= 7'h00;
		end else if (avsWrite && !avsWaitRequest && avsByteEnable[0]
				&& avsAddress == `EMB_REG_CTRL) begin
			shCtrl <= avsWriteData[6:0];
		end
	end
	// effective signs, zero while the sign controls are unused
	assign effA = shCtrl[6] & signA;
	assign effB = shCtrl[6] & signB;
	// sign-extend by the control, then keep the low half of the wide product
	function automatic logic [35:0] m18(input logic [17:0] a, b, input logic sa, sb);
		m18 = 36'($signed({sa & a[17], a})) * 36'($signed({sb & b[17], b}));
	endfunction
	function automatic logic [17:0] m9(input logic [8:0] a, b, input logic sa, sb);
		m9 = 18'($signed({sa & a[8], a})) * 18'($signed({sb & b[8], b}));
	endfunction
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_MUL_SINGLE: assert property (
		shCtrl[5:0] == 6'h00 |-> product == m18(dataA, dataB, effA, effB))
		else $error("single product wrong");
	AST_MUL_DUAL: assert property (
		shCtrl[5:0] == 6'h01 |-> product == {m9(dataA[17:9], dataB[17:9], effA, effB),
			m9(dataA[8:0], dataB[8:0], effA, effB)})
		else $error("dual product wrong");
	AST_SIGNED_OUT: assert property (
		shCtrl[5:3] == 3'h0 |-> productSigned == (effA | effB))
		else $error("product sign flag wrong");
	AST_REG_OUT: assert property (
		shCtrl[5:0] == 6'h20 && !mulClr |=> shCtrl[5:0] != 6'h20 || mulClr
			|| product == ($past(mulClkEn) ? $past(m18(dataA, dataB, effA, effB))
				: $past(product)))
		else $error("registered product wrong");
	AST_CLR_OUT: assert property (
		mulClr && shCtrl[5] |-> product == 36'h0)
		else $error("clear left product");
	AST_CLR_IN: assert property (
		mulClr && shCtrl[2:1] == 2'b11 |-> product == 36'h0)
		else $error("clear left operands");
	AST_IN_REG: assert property (
		shCtrl == 7'h02 && mulClkEn && !mulClr |=> shCtrl != 7'h02 || mulClr
			|| product == 36'($past(dataA)) * 36'(dataB))
		else $error("operand A register path wrong");
	AST_SIGN_REG: assert property (
		shCtrl == 7'h48 && mulClkEn && !mulClr |=> shCtrl != 7'h48 || mulClr
			|| productSigned == ($past(signA) | signB))
		else $error("sign register path wrong");
endmodule // emb_mult_asserts
bind emb_mult_block emb_mult_asserts chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
	.avsAddress(avsAddress), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
	.avsByteEnable(avsByteEnable), .avsWaitRequest(avsWaitRequest), .mulClkEn(mulClkEn),
	.mulClr(mulClr), .dataA(dataA), .dataB(dataB), .signA(signA), .signB(signB),
	.product(product), .productSigned(productSigned));

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`include "emb_defines.vh"
module tb;
	typedef struct packed {logic [6:0] c; logic [17:0] a, b; logic sa, sb;
		logic [35:0] p; logic ps;} emb_row_t;
	logic        clk_sys, rst_n, avsRead, avsWrite, avsWaitRequest, mulClkEn, mulClr;
	logic        signA, signB, wantSa, wantSb, productSigned;
	logic [7:0]  avsAddress;
	logic [3:0]  avsByteEnable;
	logic [31:0] avsWriteData, avsReadData, rd;
	logic [17:0] dataA, dataB, wantA, wantB;
	logic [35:0] product;
	int          num_errors, checked, cycles;
	emb_row_t    rows [8] = '{
		'{7'h00, 18'h3_FFFF, 18'h3_FFFF, 1'b1, 1'b1, 36'hF_FFF8_0001, 1'b0},
		'{7'h40, 18'h3_FFFF, 18'h0_0005, 1'b1, 1'b0, 36'hF_FFFF_FFFB, 1'b1},
		'{7'h40, 18'h2_0000, 18'h2_0000, 1'b1, 1'b1, 36'h4_0000_0000, 1'b1},
		'{7'h40, 18'h2_0000, 18'h3_FFFF, 1'b0, 1'b1, 36'hF_FFFE_0000, 1'b1},
		'{7'h40, 18'h0_0003, 18'h0_0004, 1'b0, 1'b0, 36'h0_0000_000C, 1'b0},
		'{7'h01, 18'h3_FE02, 18'h3_FE03, 1'b0, 1'b0, 36'hF_F004_0006, 1'b0},
		'{7'h41, 18'h2_01FF, 18'h3_FE02, 1'b1, 1'b1, 36'h0_0403_FFFE, 1'b1},
		'{7'h41, 18'h0_03FF, 18'h3_FEFF, 1'b1, 1'b0, 36'h0_07FF_FF01, 1'b1}};
	emb_mult_block dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .mulClkEn(mulClkEn), .mulClr(mulClr),
		.dataA(dataA), .dataB(dataB), .signA(signA), .signB(signB),
		.product(product), .productSigned(productSigned));
	emb_feeder feed_u (.clk_sys(clk_sys), .rst_n(rst_n), .wantA(wantA), .wantB(wantB),
		.wantSa(wantSa), .wantSb(wantSb), .dataA(dataA), .dataB(dataB),
		.signA(signA), .signB(signB));
	// clock and a hang limit well above the whole sequence
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task report_and_stop;
		if (num_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one bus transfer held until waitrequest is seen low, then a gap cycle
	task bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		avsAddress <= ad;
		avsWriteData <= wd;
		avsWrite <= wr;
		avsRead <= !wr;
		@(posedge clk_sys);
		// only the bench timeout ends a wait that never gets its answer
		while (avsWaitRequest !== 1'b0) begin
			@(posedge clk_sys);
		end
		rd = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge clk_sys);
	endtask
	// unmapped read and table first, then byte enable, clock enable, clear, register path and reset cases
	initial begin
		{avsRead, avsWrite, mulClr, wantSa, wantSb, rst_n} = '0;
		{avsAddress, avsWriteData, wantA, wantB} = '0;
		mulClkEn = 1'b1;
		avsByteEnable = 4'hF;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, 8'h10, 32'h0);
		chk(rd, 36'h0);
		foreach (rows[i]) begin
			bus(1'b1, `EMB_REG_CTRL, {25'h0, rows[i].c});
			{wantA, wantB, wantSa, wantSb} <= {rows[i].a, rows[i].b, rows[i].sa, rows[i].sb};
			repeat (2) @(posedge clk_sys);
			chk(product, rows[i].p);
			chk(productSigned, rows[i].ps);
			bus(1'b0, `EMB_REG_PROD_LO, 32'h0);
			chk(rd, rows[i].p[31:0]);
			bus(1'b0, `EMB_REG_PROD_HI, 32'h0);
			chk(rd, {28'h0, rows[i].p[35:32]});
			bus(1'b0, `EMB_REG_STATUS, 32'h0);
			chk(rd[3:0], {rows[i].c[0], rows[i].c[6] & rows[i].sb,
				rows[i].c[6] & rows[i].sa, rows[i].ps});
		end
		avsByteEnable <= 4'h0;
		bus(1'b1, `EMB_REG_CTRL, 32'h7F);
		avsByteEnable <= 4'hF;
		bus(1'b0, `EMB_REG_CTRL, 32'h0);
		chk(rd, 36'h41);
		bus(1'b1, `EMB_REG_CTRL, 32'h26);
		{wantA, wantB, wantSa, wantSb} <= {18'h0_0005, 18'h0_0007, 2'b00};
		repeat (4) @(posedge clk_sys);
		chk(product, 36'h0_0000_0023);
		mulClkEn <= 1'b0;
		wantA <= 18'h0_0009;
		repeat (3) @(posedge clk_sys);
		chk(product, 36'h0_0000_0023);
		mulClr <= 1'b1;
		@(posedge clk_sys);
		chk(product, 36'h0);
		mulClr <= 1'b0;
		mulClkEn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk(product, 36'h0_0000_003F);
		// output register alone: one cycle of lag, bypass would show 14 at once
		bus(1'b1, `EMB_REG_CTRL, 32'h20);
		wantA <= 18'h0_0002;
		repeat (2) @(posedge clk_sys);
		chk(product, 36'h0_0000_003F);
		@(posedge clk_sys);
		chk(product, 36'h0_0000_000E);
		// A registered, B direct: old A times new B
		bus(1'b1, `EMB_REG_CTRL, 32'h02);
		{wantA, wantB} <= {18'h0_0002, 18'h0_0003};
		@(posedge clk_sys);
		{wantA, wantB} <= {18'h0_0004, 18'h0_0005};
		repeat (2) @(posedge clk_sys);
		chk(product, 36'h0_0000_000A);
		// sign A registered: flag outlives the pin by one cycle
		bus(1'b1, `EMB_REG_CTRL, 32'h48);
		{wantSa, wantSb} <= 2'b10;
		@(posedge clk_sys);
		{wantSa, wantSb} <= 2'b00;
		repeat (2) @(posedge clk_sys);
		chk(productSigned, 1'b1);
		@(posedge clk_sys);
		chk(productSigned, 1'b0);
		// reset in mid-run: bus stalls, datapath and control back to zero
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(avsWaitRequest, 1'b1);
		chk(product, 36'h0);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		bus(1'b0, `EMB_REG_CTRL, 32'h0);
		chk(rd, 36'h0);
		report_and_stop();
	end
endmodule // tb
